// ---- double_rate_audio_formatter_tb_top.sv ----
`timescale 1ns/1ps
module double_rate_audio_formatter_tb_top;
  typedef struct packed {
    logic ds; logic b48; logic [7:0] cs; logic [8:0] cs_exp;
    logic ilv; logic [4:0] lat; logic [9:0] tlo, thi, xlo, xhi;
  } draf_row_t;
  draf_row_t rows [4] = '{
    '{1'h0, 1'h1, 8'hfd, 9'h177, 1'h0, 5'h04, 10'h341, 10'h342, 10'h341, 10'h342},
    '{1'h0, 1'h0, 8'hfe, 9'h0f8, 1'h0, 5'h04, 10'h38b, 10'h38c, 10'h38b, 10'h38c},
    '{1'h1, 1'h1, 8'ha5, 9'h115, 1'h1, 5'h08, 10'h1a0, 10'h1a1, 10'h340, 10'h342},
    '{1'h1, 1'h0, 8'h5c, 9'h038, 1'h1, 5'h08, 10'h1c5, 10'h1c6, 10'h38a, 10'h38c}};
  logic                  clk, nrst, ds, b48, cs_v, en, burst, prim, took_ds;
  logic [7:0]            cs_b;
  logic                  rx_valid, rx_ready, tx_valid, sp_valid, tick, ilv;
  logic                  cs_pro, cs_na, cs_copy, cs_locked;
  draf_pkg::draf_frame_t rx_data, tx_data;
  draf_pkg::draf_smp_t   sp_l, sp_r;
  draf_pkg::draf_emph_t  cs_emph;
  draf_pkg::draf_fs_t    cs_fs;
  logic [4:0]            lat;
  logic [5:0]            safe;
  int                    n_fail, total_checks, cyc, t_tick, t_tx, gap_tick, gap_tx, n_sp, n_took, exp_lat, lim;
  draf_pkg::draf_frame_t fq [$];
  logic [47:0]           sq [$];

  draf_top i_dut (.CLK(clk), .NRST(nrst), .DOUBLE_RATE_MODE(ds), .BASE_RATE_48K(b48),
    .RX_VALID(rx_valid), .RX_READY(rx_ready), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .SP_VALID(sp_valid), .SP_LEFT(sp_l), .SP_RIGHT(sp_r), .CS_VALID(cs_v), .CS_BYTE0(cs_b),
    .CS_PRO(cs_pro), .CS_NONAUDIO(cs_na), .CS_EMPH(cs_emph), .CS_COPY(cs_copy), .CS_FS(cs_fs),
    .CS_LOCKED(cs_locked), .SAMPLE_TICK(tick), .INTERLEAVE_ON(ilv), .PASS_LATENCY(lat), .SAFETY_OFFSET(safe));
  draf_link_src i_src (.clk(clk), .nrst(nrst), .en(en), .burst(burst), .ilv(ilv), .tick(tick),
    .ready(rx_ready), .valid(rx_valid), .data(rx_data));

  task chk(input string nm, input logic [191:0] e, input logic [191:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_in(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      n_fail++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wait_sp(input int n);
    n_sp = 0;
    lim = 30000;
    while (n_sp < n && lim > 0) begin @(posedge clk); lim--; end
    chk_in("sample pulses", n, n + 1, n_sp);
  endtask
  task drain;
    lim = 30000;
    while ((sq.size() > 0 || fq.size() > 0) && lim > 0) begin @(posedge clk); lim--; end
    chk_in("words left", 0, 0, sq.size() + fq.size());
    repeat (2) @(posedge tick);
  endtask

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // scoreboard: frames and stereo pairs expected in arrival order
  always @(posedge clk) begin
    logic [47:0] e;
    draf_pkg::draf_frame_t f;
    cyc++;
    if (!nrst) begin
      fq.delete();
      sq.delete();
      took_ds = 1'h0;
    end else begin
      if (took_ds) chk("ready after double take", 1'h0, rx_ready);
      took_ds = rx_valid && rx_ready && ilv;
      if (rx_valid && rx_ready) begin
        n_took++;
        fq.push_back(rx_data);
        if (ilv) begin
          sq.push_back({rx_data[23:0], rx_data[71:48]});
          sq.push_back({rx_data[47:24], rx_data[95:72]});
        end else sq.push_back({rx_data[23:0], rx_data[47:24]});
      end
      if (sp_valid) begin
        if (prim) chk_in("words held at first output", exp_lat, exp_lat + 2, sq.size());
        prim = 1'h0;
        n_sp++;
        e = (sq.size() > 0) ? sq.pop_front() : 'x;
        chk("stereo pair", e, {sp_l, sp_r});
      end
      if (tx_valid) begin
        gap_tx = cyc - t_tx;
        t_tx = cyc;
        f = (fq.size() > 0) ? fq.pop_front() : 'x;
        chk("link frame", f, tx_data);
      end
    end
    if (tick) begin
      gap_tick = cyc - t_tick;
      t_tick = cyc;
    end
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected finish seen timeout");
    test_done;
  end

  initial begin
    {n_fail, total_checks, cyc, t_tick, t_tx, gap_tick, gap_tx, n_sp, n_took} = '0;
    {prim, took_ds, nrst, ds, b48, cs_v, en, burst} = 8'h00;
    cs_b = 8'h00;
    exp_lat = 4;
    repeat (10) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    #1;
    chk("reset outputs", {5'h04, 6'h20, 1'h1, 1'h0}, {lat, safe, rx_ready, tx_valid});
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clk);
      ds   <= rows[i].ds;
      b48  <= rows[i].b48;
      cs_v <= 1'h1;
      cs_b <= rows[i].cs;
      @(posedge clk);
      cs_v <= 1'h0;
      repeat (4) @(posedge clk);
      #1;
      chk("status decode", rows[i].cs_exp, {cs_pro, cs_na, cs_emph, cs_copy, cs_fs, cs_locked});
      chk("interleave", rows[i].ilv, ilv);
      chk("pass latency", rows[i].lat, lat);
      chk("safety offset", 6'h20, safe);
      exp_lat = rows[i].lat;
      prim = 1'h1;
      @(posedge clk);
      en <= 1'h1;
      wait_sp(6);
      chk_in("sample spacing", rows[i].tlo, rows[i].thi, gap_tick);
      chk_in("link frame spacing", rows[i].xlo, rows[i].xhi, gap_tx);
      @(posedge clk);
      en <= 1'h0;
      drain;
      $display("mode row %0d done", i);
    end
    // fill the buffer until refused, then let it run dry
    @(posedge clk);
    ds    <= 1'h0;
    b48   <= 1'h1;
    repeat (5) @(posedge clk);
    n_took = 0;
    burst <= 1'h1;
    en    <= 1'h1;
    lim = 200;
    while (rx_ready !== 1'h0 && lim > 0) begin @(posedge clk); lim--; end
    chk_in("frames taken until full", 16, 17, n_took);
    burst <= 1'h0;
    en    <= 1'h0;
    drain;
    $display("buffer test done");
    // reset in mid traffic while double rate runs
    @(posedge clk);
    ds   <= 1'h1;
    cs_v <= 1'h1;
    cs_b <= 8'hff;
    @(posedge clk);
    cs_v <= 1'h0;
    // let the link source see the new mode before it offers a frame
    repeat (3) @(posedge clk);
    en   <= 1'h1;
    wait_sp(2);
    @(posedge clk);
    nrst <= 1'h0;
    en   <= 1'h0;
    @(posedge clk);
    #1;
    chk("mid reset outputs", {5'h04, 6'h20, 4'h8}, {lat, safe, rx_ready, tx_valid, ilv, cs_pro});
    @(posedge clk);
    nrst <= 1'h1;
    ds   <= 1'h0;
    repeat (5) @(posedge clk);
    $display("mid reset test done");
    test_done;
  end
endmodule

// ---- draf_fifo.sv ----
`timescale 1ns/1ps
module draf_fifo #(
  parameter int W     = 192,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // both ends
  draf_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic [W-1:0] dout_q;

  wire          push   = f.in_valid && f.in_ready;
  wire          pop    = f.out_valid && f.out_ready;
  wire [AW:0]   cnt    = wr_q - rd_q;
  wire [AW:0]   rd_nxt = pop ? rd_q + (AW+1)'(1) : rd_q;
  // a word written where the next read lands must bypass the array
  wire          bypass = push && (wr_q[AW-1:0] == rd_nxt[AW-1:0]);

  assign f.in_ready  = cnt != (AW+1)'(DEPTH);
  assign f.out_valid = cnt != '0;
  assign f.out_data  = dout_q;
  assign f.level     = cnt;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= f.in_data;
    end
  end

  always_ff @(posedge clk) begin
    dout_q <= bypass ? f.in_data : mem[rd_nxt[AW-1:0]];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= push ? wr_q + (AW+1)'(1) : wr_q;
      rd_q <= rd_nxt;
    end
  end

  a_fifo_bound : assert property (@(posedge clk) disable iff (!nrst)
    cnt <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
endmodule

// ---- draf_fifo_if.sv ----
`timescale 1ns/1ps
interface draf_fifo_if #(parameter int W = 192, parameter int LW = 5);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  logic [LW-1:0] level;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data, output level);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data, input level);
endinterface

// ---- draf_link_src.sv ----
`timescale 1ns/1ps
// far-side optical source; a frame is held until taken, then the lines scramble
module draf_link_src (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // pacing
  input  wire logic             en,
  input  wire logic             burst,
  input  wire logic             ilv,
  input  wire logic             tick,
  // link
  input  wire logic             ready,
  output logic                  valid,
  output draf_pkg::draf_frame_t data
);
  logic [7:0] seq_q;
  logic       pend_q;
  logic       ph_q;

  function automatic draf_pkg::draf_frame_t mk(input logic [7:0] s);
    for (int k = 0; k < 8; k++) mk[k*24 +: 24] = {s, 8'(k + 1), 8'h3c};
  endfunction

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid  <= 1'h0;
      data   <= '1;
      seq_q  <= 8'h00;
      pend_q <= 1'h0;
      ph_q   <= 1'h0;
    end else begin
      if (valid) begin
        if (ready) begin
          valid <= 1'h0;
          data  <= ~data;
          seq_q <= seq_q + 8'h01;
        end
      end else if (en && (burst || pend_q)) begin
        valid  <= 1'h1;
        data   <= mk(seq_q);
        pend_q <= 1'h0;
      end
      if (en && tick) begin
        ph_q <= ~ph_q;
        if (!ilv || ph_q) pend_q <= 1'h1;
      end
    end
  end
endmodule

// ---- draf_map.svh ----
// How it works
// - single-rate digital pass-through holds four sample periods of latency
// - double-rate pass-through holds eight sample periods, optical and coax alike
// - double-rate mode doubles the internal sample clock: 88.2 or 96 kHz
// - sample words stay 24 bits wide in both rates
// - double-rate mode always turns on interleaving on the optical link
// - channel n goes to link channels 2n-1 and 2n, first sample on odd
// - interleaved optical frames still leave at single rate, 44.1 or 48 kHz
// - status bit 0 picks professional or consumer layout; bit 1 flags non-audio
// - a fixed safety offset of 32 samples is reported for latency sums
`ifndef DRAF_MAP_SVH
`define DRAF_MAP_SVH

`define DRAF_SMP_W      24
`define DRAF_CH         8
`define DRAF_PAIRS      4
`define DRAF_FRAME_W    192
`define DRAF_FIFO_DEPTH 16
`define DRAF_LVL_W      5

`define DRAF_CLK_HZ     26'h2625a00
`define DRAF_RATE_44K1  26'h000ac44
`define DRAF_RATE_48K   26'h000bb80

`define DRAF_LAT_SS     5'h04
`define DRAF_LAT_DS     5'h08
`define DRAF_SAFETY     6'h20

`define DRAF_CS_PRO_BIT   0
`define DRAF_CS_AUDIO_BIT 1
`define DRAF_CS_PEMPH_LSB 2
`define DRAF_CS_LOCK_BIT  5
`define DRAF_CS_PFS_LSB   6
`define DRAF_CS_COPY_BIT  2
`define DRAF_CS_CEMPH_LSB 3

`endif

// ---- draf_pkg.sv ----
package draf_pkg;
  typedef logic [23:0]  draf_smp_t;
  typedef logic [191:0] draf_frame_t;
  typedef logic [2:0]   draf_emph_t;
  typedef logic [1:0]   draf_fs_t;
endpackage

// ---- draf_top.sv ----
`timescale 1ns/1ps
`include "draf_map.svh"
module draf_top (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 NRST,
  // mode pins
  input  wire logic                 DOUBLE_RATE_MODE,
  input  wire logic                 BASE_RATE_48K,
  // optical link receive
  input  wire logic                 RX_VALID,
  output logic                      RX_READY,
  input  wire draf_pkg::draf_frame_t RX_DATA,
  // optical link transmit
  output logic                      TX_VALID,
  output draf_pkg::draf_frame_t     TX_DATA,
  // coax stereo transmit
  output logic                      SP_VALID,
  output draf_pkg::draf_smp_t       SP_LEFT,
  output draf_pkg::draf_smp_t       SP_RIGHT,
  // channel status byte 0
  input  wire logic                 CS_VALID,
  input  wire logic [7:0]           CS_BYTE0,
  output logic                      CS_PRO,
  output logic                      CS_NONAUDIO,
  output draf_pkg::draf_emph_t      CS_EMPH,
  output logic                      CS_COPY,
  output draf_pkg::draf_fs_t        CS_FS,
  output logic                      CS_LOCKED,
  // status
  output logic                      SAMPLE_TICK,
  output logic                      INTERLEAVE_ON,
  output logic [`DRAF_LVL_W-1:0]    PASS_LATENCY,
  output logic [5:0]                SAFETY_OFFSET
);
  localparam int SW          = `DRAF_SMP_W;
  localparam int GAP_MIN     = int'(`DRAF_CLK_HZ / (2 * `DRAF_RATE_48K));
  localparam int GAP_MAX     = int'(`DRAF_CLK_HZ / `DRAF_RATE_44K1) + 1;
  localparam int GAP_DS_MAX  = int'(`DRAF_CLK_HZ / (2 * `DRAF_RATE_44K1)) + 1;
  localparam int LINK_MIN    = int'(`DRAF_CLK_HZ / `DRAF_RATE_48K);

  // mode pins come from outside: two flops first
  logic [1:0]  pin_s1_q;
  logic [1:0]  pin_s2_q;
  logic [1:0]  mode_q;
  logic [25:0] acc_q;
  logic        tick_q;
  logic        primed_q;
  logic        phase_q;
  logic        pend_q;
  draf_pkg::draf_frame_t pend_b_q;
  draf_pkg::draf_frame_t half_a_q;
  draf_pkg::draf_frame_t rx_a;
  draf_pkg::draf_frame_t rx_b;
  draf_pkg::draf_frame_t tx_ilv;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      mode_q   <= '0;
    end else begin
      pin_s1_q <= {BASE_RATE_48K, DOUBLE_RATE_MODE};
      pin_s2_q <= pin_s1_q;
      mode_q   <= pin_s2_q;
    end
  end

  wire ds       = pin_s2_q[0];
  wire b48      = pin_s2_q[1];
  wire mode_chg = mode_q != pin_s2_q;

  // fractional divider: exact average rate, period jitters by one cycle
  wire [25:0] base_inc = b48 ? `DRAF_RATE_48K : `DRAF_RATE_44K1;
  wire [25:0] inc      = ds ? {base_inc[24:0], 1'b0} : base_inc;
  wire [25:0] acc_sum  = acc_q + inc;
  wire        tick_hit = acc_sum >= `DRAF_CLK_HZ;
  wire [25:0] acc_d    = tick_hit ? acc_sum - `DRAF_CLK_HZ : acc_sum;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      acc_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q  <= acc_d;
      tick_q <= tick_hit;
    end
  end

  draf_fifo_if #(.W(`DRAF_FRAME_W), .LW(`DRAF_LVL_W)) ff ();

  draf_fifo #(.W(`DRAF_FRAME_W), .DEPTH(`DRAF_FIFO_DEPTH)) u_fifo (
    .clk  (CLK),
    .nrst (NRST),
    .f    (ff.fifo)
  );

  // pair split on receive and pair join on transmit
  genvar n;
  generate
    for (n = 0; n < `DRAF_PAIRS; n++) begin : g_pair
      assign rx_a[n*SW +: SW]         = RX_DATA[2*n*SW +: SW];
      assign rx_b[n*SW +: SW]         = RX_DATA[(2*n+1)*SW +: SW];
      assign tx_ilv[2*n*SW +: SW]     = half_a_q[n*SW +: SW];
      assign tx_ilv[(2*n+1)*SW +: SW] = ff.out_data[n*SW +: SW];
    end
  endgenerate
  assign rx_a[`DRAF_FRAME_W-1:`DRAF_PAIRS*SW] = '0;
  assign rx_b[`DRAF_FRAME_W-1:`DRAF_PAIRS*SW] = '0;

  // receive: in double rate one link frame gives two samples
  wire rx_take = RX_VALID && RX_READY;
  assign RX_READY    = ff.in_ready && !pend_q;
  assign ff.in_valid = pend_q || RX_VALID;
  assign ff.in_data  = pend_q ? pend_b_q : (ds ? rx_a : RX_DATA);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pend_q <= 1'b0;
    end else if (rx_take && ds) begin
      pend_q <= 1'b1;
    end else if (ff.in_ready) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (rx_take) begin
      pend_b_q <= rx_b;
    end
  end

  // output starts once the buffer holds the target depth of samples
  wire [`DRAF_LVL_W-1:0] lat_tgt = ds ? `DRAF_LAT_DS : `DRAF_LAT_SS;
  wire pop      = tick_q && primed_q && ff.out_valid;
  wire underrun = tick_q && primed_q && !ff.out_valid;
  wire tx_fire  = pop && (!ds || phase_q);
  assign ff.out_ready = pop;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      primed_q <= 1'b0;
      phase_q  <= 1'b0;
    end else if (mode_chg || underrun) begin
      // restart cleanly; latency is rebuilt from the new target
      primed_q <= 1'b0;
      phase_q  <= 1'b0;
    end else begin
      primed_q <= primed_q || (ff.level >= lat_tgt);
      phase_q  <= (pop && ds) ? !phase_q : phase_q;
    end
  end

  always_ff @(posedge CLK) begin
    if (pop && ds && !phase_q) begin
      half_a_q <= ff.out_data;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TX_VALID <= 1'b0;
      TX_DATA  <= '0;
      SP_VALID <= 1'b0;
      SP_LEFT  <= '0;
      SP_RIGHT <= '0;
    end else begin
      TX_VALID <= tx_fire;
      SP_VALID <= pop;
      if (tx_fire) begin
        TX_DATA <= ds ? tx_ilv : ff.out_data;
      end
      if (pop) begin
        SP_LEFT  <= ff.out_data[0 +: SW];
        SP_RIGHT <= ff.out_data[SW +: SW];
      end
    end
  end

  // channel status byte 0 decode
  wire cs_pro = CS_BYTE0[`DRAF_CS_PRO_BIT];
  wire [2:0] emph_sel = cs_pro ? CS_BYTE0[`DRAF_CS_PEMPH_LSB +: 3] : CS_BYTE0[`DRAF_CS_CEMPH_LSB +: 3];

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      CS_PRO      <= 1'b0;
      CS_NONAUDIO <= 1'b0;
      CS_EMPH     <= '0;
      CS_COPY     <= 1'b0;
      CS_FS       <= '0;
      CS_LOCKED   <= 1'b0;
    end else if (CS_VALID) begin
      CS_PRO      <= cs_pro;
      CS_NONAUDIO <= CS_BYTE0[`DRAF_CS_AUDIO_BIT];
      CS_EMPH     <= emph_sel;
      CS_COPY     <= !cs_pro && CS_BYTE0[`DRAF_CS_COPY_BIT];
      CS_FS       <= cs_pro ? CS_BYTE0[`DRAF_CS_PFS_LSB +: 2] : 2'h0;
      CS_LOCKED   <= cs_pro && CS_BYTE0[`DRAF_CS_LOCK_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      SAMPLE_TICK   <= 1'b0;
      INTERLEAVE_ON <= 1'b0;
      PASS_LATENCY  <= `DRAF_LAT_SS;
      SAFETY_OFFSET <= `DRAF_SAFETY;
    end else begin
      SAMPLE_TICK   <= tick_q;
      INTERLEAVE_ON <= ds;
      PASS_LATENCY  <= lat_tgt;
      SAFETY_OFFSET <= `DRAF_SAFETY;
    end
  end

  // helpers that only the checks read
  logic [10:0] gap_q;
  logic [10:0] tx_gap_q;
  logic        seen_q;
  logic        tx_seen_q;
  logic        chg_q;
  logic        tx_chg_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      gap_q     <= '0;
      tx_gap_q  <= '0;
      seen_q    <= 1'b0;
      tx_seen_q <= 1'b0;
      chg_q     <= 1'b0;
      tx_chg_q  <= 1'b0;
    end else begin
      gap_q     <= tick_q ? 11'h001 : (&gap_q ? gap_q : gap_q + 11'h001);
      tx_gap_q  <= TX_VALID ? 11'h001 : (&tx_gap_q ? tx_gap_q : tx_gap_q + 11'h001);
      seen_q    <= seen_q || tick_q;
      tx_seen_q <= tx_seen_q || TX_VALID;
      chg_q     <= mode_chg || (chg_q && !tick_q);
      tx_chg_q  <= mode_chg || (tx_chg_q && !TX_VALID);
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_ss_prime_depth : assert property (
    $rose(primed_q) && !$past(ds) && !$past(mode_chg) && $past(ff.level, 2) < `DRAF_LAT_SS
    |-> $past(ff.level) == `DRAF_LAT_SS)
    else $error("single rate output did not start at four samples");
  a_ds_prime_depth : assert property (
    $rose(primed_q) && $past(ds) && !$past(mode_chg) && $past(ff.level, 2) < `DRAF_LAT_DS
    |-> $past(ff.level) == `DRAF_LAT_DS)
    else $error("double rate output did not start at eight samples");
  a_tick_period : assert property (
    tick_q && seen_q && !chg_q |-> gap_q >= GAP_MIN && gap_q <= GAP_MAX)
    else $error("sample tick spacing out of range");
  a_ds_tick_fast : assert property (
    tick_q && seen_q && !chg_q && !mode_chg && ds |-> gap_q <= GAP_DS_MAX)
    else $error("double rate tick not doubled");
  a_tx_pair_order : assert property (
    TX_VALID && INTERLEAVE_ON && $past(ds) |->
    TX_DATA[0 +: SW] == $past(half_a_q[0 +: SW]) && TX_DATA[SW +: SW] == $past(ff.out_data[0 +: SW]))
    else $error("interleaved pair out of order");
  a_link_frame_rate : assert property (
    TX_VALID && tx_seen_q && !tx_chg_q && $past(ds) |-> tx_gap_q >= LINK_MIN)
    else $error("interleaved link frames faster than single rate");
  a_cs_pro_layout : assert property (
    CS_VALID && CS_BYTE0[0] |=> CS_PRO && !CS_COPY && CS_EMPH == $past(CS_BYTE0[4:2]))
    else $error("professional status decoded wrongly");
  a_cs_con_layout : assert property (
    CS_VALID && !CS_BYTE0[0] |=> !CS_PRO && CS_FS == 2'h0 && CS_EMPH == $past(CS_BYTE0[5:3])
    && CS_NONAUDIO == $past(CS_BYTE0[1]))
    else $error("consumer status decoded wrongly");
  a_rx_split_order : assert property (
    rx_take && ds |-> ff.in_data[0 +: SW] == RX_DATA[0 +: SW]
    ##1 (pend_q && ff.in_valid && ff.in_data[0 +: SW] == $past(RX_DATA[SW +: SW])))
    else $error("receive pair split out of order");
  a_safety_fixed : assert property (
    ##1 SAFETY_OFFSET == `DRAF_SAFETY)
    else $error("safety offset not reported");

  c_ds_link_frame : cover property (TX_VALID && INTERLEAVE_ON);
  c_ss_link_frame : cover property (TX_VALID && !INTERLEAVE_ON);
  c_underrun      : cover property (underrun);
  c_cs_pro        : cover property (CS_VALID && CS_BYTE0[0]);
endmodule
